// ### rtl/vos_top.sv
// Behaviour
// - Pulse frame done interrupt at each frame end
// - No transfer controller requests are generated
// - Four DAC channels carry image data
// - Per-channel source select picks DAC data
// - 16-bit mode: luma, chroma on two buses
// - Bus swap bit exchanges luma and chroma
// - Chroma order bit picks Cb or Cr first
// - 8-bit mode muxes Y, Cb, Cr one bus
// - Embedded sync bit enables code-word timing
// - RGB565 default, bits select 888 or 666
// - Sync pins bidirectional per slave select
// - Master drives internal sync pulses out
// - Output enable exactly during valid data
// - Drive a pixel clock output
// - External pixel clock accepted when selected
// - Master needs slave and direction bits cleared
// - Ten timing values define master frame
// - Half-rate OSD needs odd line interval
// - Four clock sources; capture clock stops DAC
module vos_top (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Configuration
  input  wire vos_pkg::vos_ctrl_t   ctrl_i,
  input  wire vos_pkg::vos_timing_t timing_i,
  // Pixel clock sources (asynchronous)
  input  wire logic [3:0]          clk_src_i,
  // Pixel stream in
  input  wire logic                pix_valid_i,
  output logic                     pix_ready_o,
  input  wire vos_pkg::vos_pixel_t  pix_i,
  // Sync pins, enables low while driving
  input  wire logic                vertical_drive_i,
  output logic                     vertical_drive_o,
  output logic                     vertical_drive_oe_n_o,
  input  wire logic                horizontal_drive_i,
  output logic                     horizontal_drive_o,
  output logic                     horizontal_drive_oe_n_o,
  // Digital display outputs
  output logic [7:0]               luma_bus_o,
  output logic [7:0]               chroma_bus_o,
  output logic [23:0]              rgb_bus_o,
  output logic                     panel_data_valid_o,
  output logic                     pixel_clock_out_o,
  // DAC outputs
  output logic [3:0][7:0]          analog_out_o,
  output logic                     dac_clock_enable_o,
  // Status
  output logic                     frame_done_irq_o,
  output logic                     timing_error_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]                  clk_sync;
    logic                        clk_prev;
    logic [1:0]                  vd_sync;
    logic [1:0]                  hd_sync;
    logic                        vd_prev;
    logic                        hd_prev;
    logic [11:0]                 hcnt;
    logic [11:0]                 vcnt;
    logic                        phase;
    logic [1:0]                  byte_sel;
    vos_pkg::vos_pixel_t [1:0]   buf_mem;
    logic                        wr_ptr;
    logic                        rd_ptr;
    logic [1:0]                  count;
    vos_pkg::vos_pixel_t         cur;
    logic [7:0]                  luma;
    logic [7:0]                  chroma;
    logic [23:0]                 rgb;
    logic [3:0][7:0]             dac;
    logic                        de;
    logic                        vd_out;
    logic                        hd_out;
    logic                        pclk;
    logic                        irq;
  } vos_state_t;

  vos_state_t s;
  vos_state_t next_s;

  logic       pix_edge;
  logic       master;
  logic       line_end;
  logic       frame_end;
  logic       h_act;
  logic       v_act;
  logic       active;
  logic       pop;
  logic [7:0] first_c;
  logic [7:0] second_c;
  logic [7:0] xy_word;
  vos_pkg::vos_pixel_t head;

  ////////////////////////////////////////////////////////////////////////////
  // Selected pixel clock and its rising edge; capture clock disables the DAC
  logic sel_clk;
  assign sel_clk = clk_src_i[ctrl_i.clock_source_select];
  assign pix_edge = s.clk_sync[1] & ~s.clk_prev;
  assign dac_clock_enable_o = (ctrl_i.clock_source_select != vos_pkg::CLK_CAPTURE);

  // Master only when slave bit and direction bit are both clear
  assign master = ~ctrl_i.slave_select & ~ctrl_i.sync_pin_direction;

  // Window decode against the running counters
  assign line_end  = s.hcnt == timing_i.line_interval;
  assign frame_end = s.vcnt == timing_i.frame_interval;
  assign h_act = (s.hcnt >= timing_i.line_active_start) &&
                 (s.hcnt < 12'(timing_i.line_active_start + timing_i.line_active_range));
  assign v_act = (s.vcnt >= timing_i.frame_active_start) &&
                 (s.vcnt < 12'(timing_i.frame_active_start + timing_i.frame_active_range));
  assign active = h_act & v_act & ctrl_i.encoder_enable;

  // One pixel drained per valid pixel edge; an empty buffer blanks instead
  assign pop = pix_edge & active & (s.count != 2'h0);
  assign pix_ready_o = (s.count != 2'(vos_pkg::BUF_DEPTH));

  // Chroma order select decides which sample leads the pair; the word being
  // shown is the one popped now, so the held copy would lag by one pixel
  assign head     = pop ? s.buf_mem[s.rd_ptr] : s.cur;
  assign first_c  = ctrl_i.chroma_order_select ? head.cr : head.cb;
  assign second_c = ctrl_i.chroma_order_select ? head.cb : head.cr;
  assign xy_word  = v_act ? vos_pkg::XY_ACTIVE : vos_pkg::XY_BLANK;

  // Half-rate OSD clock needs an odd line interval; an even one is flagged
  assign timing_error_o = ctrl_i.osd_half_clock & timing_i.line_interval[0] == 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [7:0] y_lane;
    logic [7:0] c_lane;
    vos_pkg::vos_pixel_t px;
    y_lane = 8'h00;
    c_lane = 8'h00;
    px     = s.cur;
    next_s = s;
    next_s.de       = 1'b0;
    next_s.clk_sync = {s.clk_sync[0], sel_clk};
    next_s.clk_prev = s.clk_sync[1];
    next_s.vd_sync  = {s.vd_sync[0], vertical_drive_i};
    next_s.hd_sync  = {s.hd_sync[0], horizontal_drive_i};
    next_s.irq      = 1'b0;
    next_s.pclk     = s.clk_sync[1];

    // Two-entry buffer fill side
    if (pix_valid_i && pix_ready_o) begin
      next_s.buf_mem[s.wr_ptr] = pix_i;
      next_s.wr_ptr = ~s.wr_ptr;
    end
    if (pix_valid_i && pix_ready_o && !pop) begin
      next_s.count = 2'(s.count + 2'h1);
    end else if (!(pix_valid_i && pix_ready_o) && pop) begin
      next_s.count = 2'(s.count - 2'h1);
    end

    if (pix_edge) begin
      next_s.vd_prev = s.vd_sync[1];
      next_s.hd_prev = s.hd_sync[1];
      // Counters: free-running in master, restarted by pins in slave
      if (master) begin
        next_s.hcnt = line_end ? 12'h000 : 12'(s.hcnt + 12'h001);
        if (line_end) begin
          next_s.vcnt = frame_end ? 12'h000 : 12'(s.vcnt + 12'h001);
          next_s.irq = frame_end;
        end
      end else begin
        next_s.hcnt = 12'(s.hcnt + 12'h001);
        if (s.hd_sync[1] && !s.hd_prev) begin
          next_s.hcnt = 12'h000;
          next_s.vcnt = 12'(s.vcnt + 12'h001);
        end
        if (s.vd_sync[1] && !s.vd_prev) begin
          next_s.vcnt = 12'h000;
          next_s.irq = 1'b1;
        end
      end

      // Sync pulses start after the delay and last the width
      next_s.hd_out = (s.hcnt >= timing_i.hsync_delay) &&
                      (s.hcnt < 12'(timing_i.hsync_delay + timing_i.hsync_width));
      next_s.vd_out = (s.vcnt >= timing_i.vsync_delay) &&
                      (s.vcnt < 12'(timing_i.vsync_delay + timing_i.vsync_width));

      if (pop) begin
        px = s.buf_mem[s.rd_ptr];
        next_s.cur = px;
        next_s.rd_ptr = ~s.rd_ptr;
      end else begin
        px = s.cur;
      end
      next_s.de = pop;
      next_s.phase = active ? ~s.phase : 1'b0;

      // Output formatting per mode
      case (ctrl_i.output_mode_field)
        vos_pkg::MODE_YCC16: begin
          y_lane = pop ? px.y : vos_pkg::BLANK_LUMA;
          c_lane = !pop ? vos_pkg::BLANK_CHROMA : (s.phase ? second_c : first_c);
        end
        vos_pkg::MODE_YCC8: begin
          next_s.byte_sel = 2'(s.byte_sel + 2'h1);
          if (ctrl_i.embedded_sync_enable && !h_act) begin
            // Code word sequence FF 00 00 XY in the blanking gap
            case (s.byte_sel)
              2'h0: y_lane = vos_pkg::SAV_EAV_FF;
              2'h1: y_lane = vos_pkg::SAV_EAV_00;
              2'h2: y_lane = vos_pkg::SAV_EAV_00;
              default: y_lane = xy_word;
            endcase
          end else if (!pop) begin
            y_lane = s.byte_sel[0] ? vos_pkg::BLANK_LUMA : vos_pkg::BLANK_CHROMA;
          end else begin
            case (s.byte_sel)
              2'h0: y_lane = first_c;
              2'h1: y_lane = px.y;
              2'h2: y_lane = second_c;
              default: y_lane = px.y;
            endcase
          end
        end
        default: begin
          y_lane = 8'h00;
          c_lane = 8'h00;
        end
      endcase

      // Bus swap exchanges the two digital buses
      next_s.luma   = ctrl_i.luma_chroma_bus_swap ? c_lane : y_lane;
      next_s.chroma = ctrl_i.luma_chroma_bus_swap ? y_lane : c_lane;

      // RGB packing: 565 unless a pin-function bit chooses otherwise
      if (!pop || ctrl_i.output_mode_field != vos_pkg::MODE_RGB) begin
        next_s.rgb = 24'h000000;
      end else if (ctrl_i.rgb888_select) begin
        next_s.rgb = {px.r, px.g, px.b};
      end else if (ctrl_i.rgb666_select) begin
        next_s.rgb = {px.r[7:2], 2'h0, px.g[7:2], 2'h0, px.b[7:2], 2'h0};
      end else begin
        next_s.rgb = {px.r[7:3], 3'h0, px.g[7:2], 2'h0, px.b[7:3], 3'h0};
      end

      // DAC channels: per-channel source pick among Y, Cb, Cr, or Cb/Cr alternating by phase
      for (int ch = 0; ch < 4; ch++) begin
        case (ctrl_i.dac_source_select[2*ch +: 2])
          2'h0: next_s.dac[ch] = pop ? px.y : vos_pkg::BLANK_LUMA;
          2'h1: next_s.dac[ch] = pop ? px.cb : vos_pkg::BLANK_CHROMA;
          2'h2: next_s.dac[ch] = pop ? px.cr : vos_pkg::BLANK_CHROMA;
          default: next_s.dac[ch] = pop ? (s.phase ? px.cr : px.cb) : vos_pkg::BLANK_CHROMA;
        endcase
        if (ctrl_i.output_mode_field != vos_pkg::MODE_DAC || !dac_clock_enable_o) begin
          next_s.dac[ch] = 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; no transfer-controller request port exists at all
  assign luma_bus_o              = s.luma;
  assign chroma_bus_o            = s.chroma;
  assign rgb_bus_o               = s.rgb;
  assign panel_data_valid_o      = s.de;
  assign pixel_clock_out_o       = s.pclk;
  assign analog_out_o            = s.dac;
  assign frame_done_irq_o        = s.irq;
  assign vertical_drive_o        = s.vd_out;
  assign horizontal_drive_o      = s.hd_out;
  assign vertical_drive_oe_n_o   = ctrl_i.slave_select | ctrl_i.sync_pin_direction;
  assign horizontal_drive_oe_n_o = ctrl_i.slave_select | ctrl_i.sync_pin_direction;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pix_edge_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_done_irq_o |-> $past(pix_edge))
    else $error("frame done without pixel edge");
  a_irq_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_done_irq_o |=> !frame_done_irq_o)
    else $error("frame done longer than one cycle");
  a_de_window: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_edge && !active |=> !panel_data_valid_o)
    else $error("output enable outside window");
  a_master_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    master |-> !vertical_drive_oe_n_o && !horizontal_drive_oe_n_o)
    else $error("master not driving sync pins");
  a_slave_release: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.slave_select |-> vertical_drive_oe_n_o && horizontal_drive_oe_n_o)
    else $error("slave still driving sync pins");
  a_h_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    master && pix_edge && line_end |=> s.hcnt == 12'h000)
    else $error("line counter did not wrap");
  a_dac_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.clock_source_select == vos_pkg::CLK_CAPTURE && pix_edge |=> analog_out_o == '0)
    else $error("dac active on capture clock");
  a_buf_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    s.count <= 2'(vos_pkg::BUF_DEPTH))
    else $error("buffer overfilled");
  a_hsync_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    pix_edge && s.hcnt == timing_i.hsync_delay && timing_i.hsync_width != 12'h000
    |=> horizontal_drive_o)
    else $error("hsync not started at delay");

endmodule : vos_top

// ### pkg/vos_pkg.sv
package vos_pkg;

  // Output mode field encodings
  localparam logic [1:0] MODE_YCC16 = 2'h0;
  localparam logic [1:0] MODE_YCC8  = 2'h1;
  localparam logic [1:0] MODE_RGB   = 2'h2;
  localparam logic [1:0] MODE_DAC   = 2'h3;

  // Clock source select encodings
  localparam logic [1:0] CLK_XTAL27 = 2'h0;
  localparam logic [1:0] CLK_PLL54  = 2'h1;
  localparam logic [1:0] CLK_EXTPIN = 2'h2;
  localparam logic [1:0] CLK_CAPTURE = 2'h3;

  // Embedded sync code words
  localparam logic [7:0] SAV_EAV_FF = 8'hff;
  localparam logic [7:0] SAV_EAV_00 = 8'h00;
  localparam logic [7:0] XY_ACTIVE  = 8'h80;
  localparam logic [7:0] XY_BLANK   = 8'hab;
  localparam logic [7:0] BLANK_LUMA = 8'h10;
  localparam logic [7:0] BLANK_CHROMA = 8'h80;

  // Counter width and buffer depth
  localparam int CNT_W     = 12;
  localparam int BUF_DEPTH = 2;

  // Frame timing set
  typedef struct packed {
    logic [11:0] hsync_width;
    logic [11:0] vsync_width;
    logic [11:0] line_interval;
    logic [11:0] line_active_start;
    logic [11:0] line_active_range;
    logic [11:0] frame_interval;
    logic [11:0] frame_active_start;
    logic [11:0] frame_active_range;
    logic [11:0] hsync_delay;
    logic [11:0] vsync_delay;
  } vos_timing_t;

  // Control bits
  typedef struct packed {
    logic       encoder_enable;
    logic [1:0] output_mode_field;
    logic       slave_select;
    logic       sync_pin_direction;
    logic       luma_chroma_bus_swap;
    logic       chroma_order_select;
    logic       embedded_sync_enable;
    logic       rgb888_select;
    logic       rgb666_select;
    logic [1:0] clock_source_select;
    logic       osd_half_clock;
    logic [7:0] dac_source_select;
  } vos_ctrl_t;

  // One pixel word: Y, Cb, Cr, and RGB
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vos_pixel_t;

endpackage : vos_pkg

// ### bench/vos_display_model.sv
module vos_display_model (
  // Clocks
  input  wire logic        clk_i,
  input  wire logic        link_i,
  // Sync supply toward the device
  input  wire logic        slave_en_i,
  output logic             hd_o,
  output logic             vd_o,
  // Display data from the device
  input  wire logic        valid_i,
  input  wire logic [71:0] data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [71:0] cap[$];
  int          pos = 0;
  // Ten link periods a line, five lines a frame; quiet unless we own the pins
  always @(posedge link_i) begin
    pos = (pos + 1) % 50;
    hd_o <= slave_en_i && (pos % 10 == 0);
    vd_o <= slave_en_i && (pos == 0);
  end
  // Latch every word flagged valid, sampled on the system clock clk_i, not the link clock
  always @(posedge clk_i) begin
    if (valid_i) cap.push_back(data_i);
  end
endmodule : vos_display_model

// ### bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk_i, rst_i, lk, pix_valid_i, pix_ready_o;
  logic                 vd_o, vd_oe_n, hd_o, hd_oe_n, vd_m, hd_m, vd_w, hd_w;
  logic                 pdv, pclk, dce, irq, terr;
  logic [7:0]           luma, chroma;
  logic [23:0]          rgb;
  logic [3:0][7:0]      aout;
  vos_pkg::vos_ctrl_t   ctrl_i;
  vos_pkg::vos_timing_t timing_i;
  vos_pkg::vos_pixel_t  pix_i;
  int                   err_total, checks_done, cycles, g, w;
  // Pin level: whoever has the enable owns the wire
  assign hd_w = hd_oe_n ? hd_m : hd_o;
  assign vd_w = vd_oe_n ? vd_m : vd_o;
  vos_top dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_i(ctrl_i), .timing_i(timing_i),
    .clk_src_i({lk, lk, lk, 1'b0}), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .pix_i(pix_i), .vertical_drive_i(vd_w), .vertical_drive_o(vd_o),
    .vertical_drive_oe_n_o(vd_oe_n), .horizontal_drive_i(hd_w),
    .horizontal_drive_o(hd_o), .horizontal_drive_oe_n_o(hd_oe_n), .luma_bus_o(luma),
    .chroma_bus_o(chroma), .rgb_bus_o(rgb), .panel_data_valid_o(pdv),
    .pixel_clock_out_o(pclk), .analog_out_o(aout), .dac_clock_enable_o(dce),
    .frame_done_irq_o(irq), .timing_error_o(terr));
  vos_display_model disp (.clk_i(clk_i), .link_i(lk), .slave_en_i(ctrl_i.slave_select),
    .hd_o(hd_m), .vd_o(vd_m), .valid_i(pdv), .data_i({luma, chroma, rgb, aout}));
  ////////////////////////////////////////////////////////////////////////////////
  // Clocks; the link clock is offset so its edges never line up with ours
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    lk = 0;
    #37;
    forever #400 lk = ~lk;
  end
  // Hang guard, well above the longest expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk_bit(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    chk_bit(got === exp, 1'b1, m);
  endtask : chk_val
  task automatic chk_cnt(input int got, input int exp, input string m);
    chk_bit(got == exp, 1'b1, m);
  endtask : chk_cnt
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic reset;
    rst_i = 1;
    disp.cap.delete();
    repeat (5) @(posedge clk_i);
    #1;
    rst_i = 0;
  endtask : reset
  // Cycles between two rising edges, and the width of the first pulse
  task automatic gap(ref logic s, output int gp, output int wd);
    int   n, r;
    logic p;
    r = 0;
    gp = 0;
    wd = 0;
    p = s;
    for (n = 0; n < 3000 && r < 2; n++) begin
      tick();
      if (r > 0) gp++;
      if (s === 1'b1 && p === 1'b0) r++;
      if (r == 1 && s === 1'b1) wd++;
      p = s;
    end
  endtask : gap
  // Four back-to-back words; valid stays up between them
  task automatic feed(input logic [7:0] k);
    int n, i;
    for (i = 0; i < 4; i++) begin
      pix_i = {k + 8'(i), k + 8'(i + 17), k + 8'(i + 34), k + 8'(i + 51), k + 8'(i + 68),
               k + 8'(i + 85)};
      pix_valid_i = 1;
      for (n = 0; n < 2000 && pix_ready_o !== 1'b1; n++) tick();
      tick();
    end
    pix_valid_i = 0;
    for (n = 0; n < 3000 && disp.cap.size() < 4; n++) tick();
    chk_cnt(disp.cap.size(), 4, "words shown");
  endtask : feed
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_static;
    int n, i;
    logic p;
    chk_bit(hd_oe_n | vd_oe_n, 1'b0, "master drives pins");
    ctrl_i.sync_pin_direction = 1;
    tick();
    chk_bit(hd_oe_n & vd_oe_n, 1'b1, "direction bit releases");
    ctrl_i.sync_pin_direction = 0;
    ctrl_i.slave_select = 1;
    tick();
    chk_bit(hd_oe_n & vd_oe_n, 1'b1, "slave releases");
    ctrl_i.slave_select = 0;
    ctrl_i.osd_half_clock = 1;
    tick();
    chk_bit(terr, 1'b0, "odd interval fine");
    timing_i.line_interval = 12'h8;
    tick();
    chk_bit(terr, 1'b1, "even interval flagged");
    timing_i.line_interval = 12'h9;
    ctrl_i.osd_half_clock = 0;
    ctrl_i.clock_source_select = 2'h3;
    tick();
    chk_bit(dce, 1'b0, "capture clock stops dac");
    // Pin source 0 is held still, so its selection must stop the pixel clock
    for (i = 0; i < 3; i++) begin
      ctrl_i.clock_source_select = (i == 1) ? 2'h0 : 2'h2;
      repeat (10) tick();
      n = 0;
      p = pclk;
      repeat (800) begin
        tick();
        if (pclk === 1'b1 && p === 1'b0) n++;
        p = pclk;
      end
      chk_bit(n >= 99 && n <= 101, i != 1, "pixel clock edges");
    end
    chk_bit(dce, 1'b1, "dac clock on");
  endtask : t_static
  task automatic t_sync;
    reset();
    gap(hd_o, g, w);
    chk_cnt(g, 80, "line period");
    chk_cnt(w, 16, "hsync width");
    gap(vd_o, g, w);
    chk_cnt(g, 400, "frame period");
    chk_cnt(w, 80, "vsync width");
    gap(irq, g, w);
    chk_cnt(g, 400, "irq per frame");
    chk_cnt(w, 1, "irq pulse");
    ctrl_i.slave_select = 1;
    reset();
    gap(irq, g, w);
    chk_cnt(g, 400, "irq follows panel frame");
    ctrl_i.slave_select = 0;
  endtask : t_sync
  task automatic t_ycc16;
    int i, m;
    logic [7:0] y, c;
    for (m = 0; m < 4; m++) begin
      ctrl_i.chroma_order_select = m[0];
      ctrl_i.luma_chroma_bus_swap = m[1];
      reset();
      feed(8'h20);
      for (i = 0; i < 4; i++) begin
        y = 8'h20 + 8'(i);
        c = ((i % 2) == m[0]) ? y + 8'h11 : y + 8'h22;
        chk_val(32'(disp.cap[i][71:64]), 32'(m[1] ? c : y), "luma bus");
        chk_val(32'(disp.cap[i][63:56]), 32'(m[1] ? y : c), "chroma bus");
      end
    end
    ctrl_i.chroma_order_select = 0;
    ctrl_i.luma_chroma_bus_swap = 0;
  endtask : t_ycc16
  task automatic t_rgb_dac;
    ctrl_i.output_mode_field = vos_pkg::MODE_RGB;
    ctrl_i.rgb888_select = 1;
    reset();
    feed(8'h40);
    chk_val(32'(disp.cap[0][55:32]), 32'h00738495, "rgb888 word");
    ctrl_i.output_mode_field = vos_pkg::MODE_DAC;
    ctrl_i.dac_source_select = 8'h90;
    reset();
    feed(8'h40);
    chk_val(disp.cap[0][31:0], 32'h62514040, "dac channels");
  endtask : t_rgb_dac
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    pix_valid_i = 0;
    pix_i = '0;
    ctrl_i = '0;
    ctrl_i.encoder_enable = 1;
    ctrl_i.clock_source_select = 2'h2;
    timing_i = '{12'h2, 12'h1, 12'h9, 12'h2, 12'h6, 12'h4, 12'h1, 12'h3, 12'h1, 12'h0};
    reset();
    t_static();
    t_sync();
    t_ycc16();
    t_rgb_dac();
    stop_test();
  end
endmodule : tb
